// [logic/wdtir_pkg.sv]
package wdtir_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [15:0] WDTIR_WR_CS_CNT_ADDR = 16'hFFA8;  // shared word write: counter or ctrl/stat
  localparam logic [15:0] WDTIR_WR_RST_ADDR    = 16'hFFAA;  // word write: reset ctrl/stat
  localparam logic [15:0] WDTIR_RD_CS_ADDR     = 16'hFFA8;
  localparam logic [15:0] WDTIR_RD_CNT_ADDR    = 16'hFFA9;
  localparam logic [15:0] WDTIR_RD_RST_ADDR    = 16'hFFAB;

  // ----------------------------------------------------------------
  // write passwords (high byte of the word)
  // ----------------------------------------------------------------
  localparam logic [7:0] WDTIR_PW_COUNT = 8'h5A;
  localparam logic [7:0] WDTIR_PW_CTRL  = 8'hA5;
  localparam logic [7:0] WDTIR_IND_CLEAR_DATA = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int WDTIR_CS_OVF_BIT  = 7;
  localparam int WDTIR_CS_MODE_BIT = 6;
  localparam int WDTIR_CS_RUN_BIT  = 5;
  localparam int WDTIR_CS_CKS_MSB  = 2;
  localparam int WDTIR_CS_CKS_LSB  = 0;
  localparam int WDTIR_RS_IND_BIT  = 7;
  localparam int WDTIR_RS_OE_BIT   = 6;

  // ----------------------------------------------------------------
  // reset values and fixed read-as-one bits
  // ----------------------------------------------------------------
  localparam logic [7:0] WDTIR_CS_RESET  = 8'h18;
  localparam logic [7:0] WDTIR_CNT_RESET = 8'h00;
  localparam logic [7:0] WDTIR_RS_RESET  = 8'h3F;
  localparam logic [7:0] WDTIR_CS_ONES   = 8'h18;
  localparam logic [7:0] WDTIR_RS_ONES   = 8'h3F;
  localparam logic [7:0] WDTIR_UNMAPPED  = 8'h00;

  // ----------------------------------------------------------------
  // timing: one state is one system clock cycle (40 ns at 25 MHz)
  // ----------------------------------------------------------------
  localparam int WDTIR_INT_RESET_STATES = 518;
  localparam int WDTIR_EXT_RESET_STATES = 132;
  localparam int WDTIR_PRESCALE_W       = 12;  // widest divisor is 4096

  // low-bit mask of the prescaler for a clock select code
  function automatic logic [WDTIR_PRESCALE_W-1:0] wdtir_div_mask(input logic [2:0] cks);
    logic [WDTIR_PRESCALE_W-1:0] m;
    m = 12'h000;
    unique case (cks)
      3'h0: m = 12'h001;  // /2
      3'h1: m = 12'h01F;  // /32
      3'h2: m = 12'h03F;  // /64
      3'h3: m = 12'h07F;  // /128
      3'h4: m = 12'h0FF;  // /256
      3'h5: m = 12'h1FF;  // /512
      3'h6: m = 12'h7FF;  // /2048
      3'h7: m = 12'hFFF;  // /4096
    endcase
    return m;
  endfunction

endpackage

// [logic/wdtir_prescaler.sv]
module wdtir_prescaler #(
  parameter int WIDTH = wdtir_pkg::WDTIR_PRESCALE_W
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [2:0]       cks_i,
  output logic                  tick_o
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             tick;
  } wdtir_pre_state_type;

  wdtir_pre_state_type s_q;
  wdtir_pre_state_type s_d;
  logic [WIDTH-1:0]    mask;

  // ------------------------------------------------------------
  // free-running divider; tick once per selected period
  // ------------------------------------------------------------
  always_comb
  begin
    mask   = WIDTH'(wdtir_pkg::wdtir_div_mask(cks_i));
    s_d    = s_q;
    s_d.cnt  = s_q.cnt + WIDTH'(1);
    s_d.tick = (s_q.cnt & mask) == mask;
  end

  // divider is never cleared by the run bit, so first period may be short
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else if (ce_i)
      s_q <= s_d;
  end

  assign tick_o = s_q.tick;

  // tick spacing: /2 selection must tick on alternate cycles
  a_tick_half_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cks_i == 3'h0 && s_q.tick |=> !s_q.tick)
    else $error("prescaler /2 ticked twice in a row");

endmodule

// [logic/wdtir_reset_pulse.sv]
module wdtir_reset_pulse #(
  parameter int INT_CYCLES = wdtir_pkg::WDTIR_INT_RESET_STATES,
  parameter int EXT_CYCLES = wdtir_pkg::WDTIR_EXT_RESET_STATES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic start_i,
  input  wire logic oe_i,
  output logic      chip_rst_o,
  output logic      ext_rst_n_o
);

  typedef struct packed {
    logic [9:0] cnt;
    logic       chip;
    logic       ext_n;
  } wdtir_pulse_state_type;

  wdtir_pulse_state_type s_q;
  wdtir_pulse_state_type s_d;

  // ------------------------------------------------------------
  // count elapsed states; internal and pin pulses end separately
  // ------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    if (!s_q.chip && start_i)
    begin
      s_d.cnt   = 10'h001;
      s_d.chip  = 1'b1;
      s_d.ext_n = !oe_i;
    end
    else if (s_q.chip)
    begin
      s_d.cnt = s_q.cnt + 10'h001;
      if (s_q.cnt == 10'(INT_CYCLES))
        s_d.chip = 1'b0;
      if (s_q.cnt == 10'(EXT_CYCLES))
        s_d.ext_n = 1'b1;
    end
  end

  // pin reset has priority: it cancels a pulse in flight
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '{cnt: 10'h000, chip: 1'b0, ext_n: 1'b1};
    else if (ce_i)
      s_q <= s_d;
  end

  assign chip_rst_o  = s_q.chip;
  assign ext_rst_n_o = s_q.ext_n;

  a_chip_pulse_len: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(chip_rst_o) |-> $past(s_q.cnt) == 10'(INT_CYCLES))
    else $error("internal reset pulse length wrong");

  a_pin_pulse_len: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ext_rst_n_o) |-> $past(s_q.cnt) == 10'(EXT_CYCLES))
    else $error("external reset pulse length wrong");

  a_pin_needs_chip: assert property (@(posedge clk_i) disable iff (rst_i)
    !ext_rst_n_o |-> chip_rst_o)
    else $error("reset pin driven outside internal reset");

endmodule

// [logic/wdtir_top.sv]
module wdtir_top #(
  parameter int INT_RESET_CYCLES = wdtir_pkg::WDTIR_INT_RESET_STATES,
  parameter int EXT_RESET_CYCLES = wdtir_pkg::WDTIR_EXT_RESET_STATES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        standby_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic        wr_word_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  output logic             rvalid_o,
  output logic             interval_interrupt_o,
  output logic             chip_reset_o,
  output logic             reset_output_pin_n_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] up_counter;
    logic       overflow_flag;
    logic       overflow_action_select;
    logic       timer_run_enable;
    logic [2:0] clock_select;
    logic       flag_seen_set;
    logic       supervisor_reset_indicator;
    logic       reset_output_enable;
    logic [7:0] rdata;
    logic       rvalid;
    logic       irq;
    logic       fire;
  } wdtir_state_type;

  localparam wdtir_state_type ST_RESET = '{
    up_counter:                 wdtir_pkg::WDTIR_CNT_RESET,
    overflow_flag:              wdtir_pkg::WDTIR_CS_RESET[wdtir_pkg::WDTIR_CS_OVF_BIT],
    overflow_action_select:     wdtir_pkg::WDTIR_CS_RESET[wdtir_pkg::WDTIR_CS_MODE_BIT],
    timer_run_enable:           wdtir_pkg::WDTIR_CS_RESET[wdtir_pkg::WDTIR_CS_RUN_BIT],
    clock_select:               wdtir_pkg::WDTIR_CS_RESET[wdtir_pkg::WDTIR_CS_CKS_MSB:wdtir_pkg::WDTIR_CS_CKS_LSB],
    flag_seen_set:              1'b0,
    supervisor_reset_indicator: wdtir_pkg::WDTIR_RS_RESET[wdtir_pkg::WDTIR_RS_IND_BIT],
    reset_output_enable:        wdtir_pkg::WDTIR_RS_RESET[wdtir_pkg::WDTIR_RS_OE_BIT],
    rdata:                      8'h00,
    rvalid:                     1'b0,
    irq:                        1'b0,
    fire:                       1'b0
  };

  wdtir_state_type s_q;
  wdtir_state_type s_d;

  logic       tick;
  logic       chip_rst;
  logic       ext_rst_n;
  logic [7:0] cs_view;
  logic [7:0] rs_view;
  logic [7:0] wr_lo;
  logic [7:0] wr_hi;
  logic       word_wr;
  logic       cnt_wr;
  logic       cs_wr;
  logic       ind_clr;
  logic       oe_wr;
  logic       overflow;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  assign wr_lo = wdata_i[7:0];
  assign wr_hi = wdata_i[15:8];

  // register views as software reads them
  always_comb
  begin
    cs_view = wdtir_pkg::WDTIR_CS_ONES;
    cs_view[wdtir_pkg::WDTIR_CS_OVF_BIT]  = s_q.overflow_flag;
    cs_view[wdtir_pkg::WDTIR_CS_MODE_BIT] = s_q.overflow_action_select;
    cs_view[wdtir_pkg::WDTIR_CS_RUN_BIT]  = s_q.timer_run_enable;
    cs_view[wdtir_pkg::WDTIR_CS_CKS_MSB:wdtir_pkg::WDTIR_CS_CKS_LSB] = s_q.clock_select;
    rs_view = wdtir_pkg::WDTIR_RS_ONES;
    rs_view[wdtir_pkg::WDTIR_RS_IND_BIT] = s_q.supervisor_reset_indicator;
    rs_view[wdtir_pkg::WDTIR_RS_OE_BIT]  = s_q.reset_output_enable;
  end

  // password decode; byte writes and wrong passwords decode to nothing
  always_comb
  begin
    word_wr = wr_i && wr_word_i;
    cnt_wr  = word_wr && addr_i == wdtir_pkg::WDTIR_WR_CS_CNT_ADDR
              && wr_hi == wdtir_pkg::WDTIR_PW_COUNT;
    cs_wr   = word_wr && addr_i == wdtir_pkg::WDTIR_WR_CS_CNT_ADDR
              && wr_hi == wdtir_pkg::WDTIR_PW_CTRL;
    ind_clr = word_wr && addr_i == wdtir_pkg::WDTIR_WR_RST_ADDR
              && wr_hi == wdtir_pkg::WDTIR_PW_CTRL
              && wr_lo == wdtir_pkg::WDTIR_IND_CLEAR_DATA;
    oe_wr   = word_wr && addr_i == wdtir_pkg::WDTIR_WR_RST_ADDR
              && wr_hi == wdtir_pkg::WDTIR_PW_COUNT;
  end

  // wrap is taken only when no counter write lands in the same cycle
  assign overflow = s_q.timer_run_enable && tick && !cnt_wr && !chip_rst
                    && s_q.up_counter == 8'hFF;

  // ----------------------------------------------------------------
  // prescaler and reset pulse generator
  // ----------------------------------------------------------------
  wdtir_prescaler #(
    .WIDTH (wdtir_pkg::WDTIR_PRESCALE_W)
  ) u_prescaler (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .cks_i  (s_q.clock_select),
    .tick_o (tick)
  );

  wdtir_reset_pulse #(
    .INT_CYCLES (INT_RESET_CYCLES),
    .EXT_CYCLES (EXT_RESET_CYCLES)
  ) u_reset_pulse (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .start_i     (s_q.fire),
    .oe_i        (s_q.reset_output_enable),
    .chip_rst_o  (chip_rst),
    .ext_rst_n_o (ext_rst_n)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    s_d.fire   = 1'b0;

    // byte reads answer one cycle later; unmapped reads return zero
    if (rd_i)
    begin
      s_d.rvalid = 1'b1;
      unique case (addr_i)
        wdtir_pkg::WDTIR_RD_CS_ADDR:
        begin
          s_d.rdata = cs_view;
          if (s_q.overflow_flag)
            s_d.flag_seen_set = 1'b1;
        end
        wdtir_pkg::WDTIR_RD_CNT_ADDR: s_d.rdata = s_q.up_counter;
        wdtir_pkg::WDTIR_RD_RST_ADDR: s_d.rdata = rs_view;
        default: s_d.rdata = wdtir_pkg::WDTIR_UNMAPPED;
      endcase
    end

    // control/status write; a 1 in the flag position does nothing
    if (cs_wr)
    begin
      s_d.overflow_action_select = wr_lo[wdtir_pkg::WDTIR_CS_MODE_BIT];
      s_d.timer_run_enable       = wr_lo[wdtir_pkg::WDTIR_CS_RUN_BIT];
      s_d.clock_select = wr_lo[wdtir_pkg::WDTIR_CS_CKS_MSB:wdtir_pkg::WDTIR_CS_CKS_LSB];
      if (!wr_lo[wdtir_pkg::WDTIR_CS_OVF_BIT] && s_q.flag_seen_set)
      begin
        s_d.overflow_flag = 1'b0;
        s_d.flag_seen_set = 1'b0;
      end
    end

    // reset control writes
    if (ind_clr)
      s_d.supervisor_reset_indicator = 1'b0;
    if (oe_wr)
      s_d.reset_output_enable = wr_lo[wdtir_pkg::WDTIR_RS_OE_BIT];

    // counter: stop clears, write beats tick
    if (!s_q.timer_run_enable)
      s_d.up_counter = 8'h00;
    else if (cnt_wr)
      s_d.up_counter = wr_lo;
    else if (tick)
      s_d.up_counter = s_q.up_counter + 8'h01;

    // overflow event: set beats a clear landing in the same cycle
    if (overflow)
    begin
      s_d.overflow_flag = 1'b1;
      if (s_q.overflow_action_select)
      begin
        s_d.supervisor_reset_indicator = 1'b1;
        s_d.fire = 1'b1;
      end
    end

    // standby clears the upper control bits, select survives
    if (standby_i)
    begin
      s_d.overflow_flag          = 1'b0;
      s_d.overflow_action_select = 1'b0;
      s_d.timer_run_enable       = 1'b0;
      s_d.flag_seen_set          = 1'b0;
      s_d.up_counter             = 8'h00;
    end

    // internal watchdog reset: timer back to reset, reset ctrl untouched
    if (chip_rst)
    begin
      s_d.up_counter             = ST_RESET.up_counter;
      s_d.overflow_flag          = ST_RESET.overflow_flag;
      s_d.overflow_action_select = ST_RESET.overflow_action_select;
      s_d.timer_run_enable       = ST_RESET.timer_run_enable;
      s_d.clock_select           = ST_RESET.clock_select;
      s_d.flag_seen_set          = 1'b0;
      s_d.fire                   = 1'b0;
    end

    // request mirrors the flag while in interval mode
    s_d.irq = s_d.overflow_flag && !s_d.overflow_action_select;
  end

  // only the pin reset reaches the indicator and output enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= ST_RESET;
    else if (ce_i)
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o              = s_q.rdata;
  assign rvalid_o             = s_q.rvalid;
  assign interval_interrupt_o = s_q.irq;
  assign chip_reset_o         = chip_rst;
  assign reset_output_pin_n_o = ext_rst_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_wrap;
    ce_i && !standby_i && overflow;
  endsequence

  sequence s_watchdog_wrap;
    s_wrap ##0 s_q.overflow_action_select;
  endsequence

  a_stop_holds_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !s_q.timer_run_enable |=> s_q.up_counter == 8'h00)
    else $error("counter not held at zero while stopped");

  a_count_steps_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !standby_i && !chip_rst && s_q.timer_run_enable && tick && !cnt_wr
    |=> s_q.up_counter == $past(s_q.up_counter) + 8'h01)
    else $error("counter did not advance by one on tick");

  a_write_beats_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !standby_i && !chip_rst && s_q.timer_run_enable && cnt_wr
    |=> s_q.up_counter == $past(wdata_i[7:0]))
    else $error("counter write lost to increment");

  a_wrap_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wrap |=> s_q.overflow_flag && s_q.up_counter == 8'h00)
    else $error("wrap did not set overflow flag");

  a_flag_needs_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !standby_i && !chip_rst && s_q.overflow_flag && !s_q.flag_seen_set
    |=> s_q.overflow_flag)
    else $error("overflow flag cleared without prior read");

  a_watchdog_fires: assert property (@(posedge clk_i) disable iff (rst_i)
    s_watchdog_wrap ##1 ce_i |=> chip_reset_o && s_q.supervisor_reset_indicator)
    else $error("watchdog wrap did not reset chip and set indicator");

  a_reset_keeps_ind: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && chip_rst && !ind_clr |=> s_q.supervisor_reset_indicator == $past(s_q.supervisor_reset_indicator)
    && !s_q.overflow_flag)
    else $error("internal reset touched indicator or left flag set");

  a_byte_write_void: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_i && !wr_word_i && !rd_i && !standby_i && !chip_rst && !overflow
    |=> $stable(cs_view) && $stable(rs_view))
    else $error("byte write changed a register");

  a_irq_tracks_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    interval_interrupt_o == (s_q.overflow_flag && !s_q.overflow_action_select))
    else $error("interrupt request does not follow flag");

  a_read_fixed_ones: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_i && addr_i == wdtir_pkg::WDTIR_RD_RST_ADDR
    |=> rvalid_o && rdata_o[5:0] == 6'h3F)
    else $error("reset ctrl reserved bits not read as one");

  a_standby_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && standby_i |=> cs_view[7:5] == 3'h0 && s_q.clock_select == $past(s_q.clock_select))
    else $error("standby handling of control bits wrong");

  a_cs_write_fields: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cs_wr && !standby_i && !chip_rst
    |=> cs_view[6:5] == $past(wr_lo[6:5]) && s_q.clock_select == $past(wr_lo[2:0]))
    else $error("control/status write did not land");

  a_ind_clear_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ind_clr && !overflow |=> !s_q.supervisor_reset_indicator)
    else $error("indicator clear write ignored");

  a_oe_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && oe_wr && !overflow
    |=> s_q.reset_output_enable == $past(wr_lo[wdtir_pkg::WDTIR_RS_OE_BIT])
    && s_q.supervisor_reset_indicator == $past(s_q.supervisor_reset_indicator))
    else $error("output enable write wrong or indicator touched");

  a_bad_pw_void: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && word_wr && !cnt_wr && !cs_wr && !ind_clr && !oe_wr
    && !rd_i && !standby_i && !chip_rst && !overflow
    |=> $stable(cs_view) && $stable(rs_view))
    else $error("refused word write changed a register");

  a_read_counter: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_i && addr_i == wdtir_pkg::WDTIR_RD_CNT_ADDR
    |=> rvalid_o && rdata_o == $past(s_q.up_counter))
    else $error("counter read returned wrong value");

endmodule

// [sim/wdtir_top_tb.sv]
module wdtir_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  // short pulse lengths keep the watchdog runs brief
  localparam int INT_N = 20;
  localparam int EXT_N = 8;
  logic        clk_i;
  logic        rst_i;
  logic        ce_i;
  logic        standby_i;
  logic [15:0] addr_i;
  logic        wr_i;
  logic        wr_word_i;
  logic [15:0] wdata_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic        rvalid_o;
  logic        irq_o;
  logic        chip_o;
  logic        pin_n_o;
  int          n_errors;
  int          tests_run;

  wdtir_top #(.INT_RESET_CYCLES(INT_N), .EXT_RESET_CYCLES(EXT_N)) wdtir_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .standby_i(standby_i), .addr_i(addr_i),
    .wr_i(wr_i), .wr_word_i(wr_word_i), .wdata_i(wdata_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .interval_interrupt_o(irq_o), .chip_reset_o(chip_o),
    .reset_output_pin_n_o(pin_n_o));

  // free-running 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // all bus tasks start and end on a falling edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic word = 1'b1);
    addr_i = a;
    wdata_i = d;
    wr_word_i = word;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    check("rvalid", {7'h00, rvalid_o}, 8'h01);
    v = rdata_o;
    // idle cycle so a following read never restrobes in the same step
    @(negedge clk_i);
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string name);
    logic [7:0] v;
    rd(a, v);
    check(name, v, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    rdchk(16'hFFA8, 8'h18, "cs_reset");
    rdchk(16'hFFA9, 8'h00, "cnt_reset");
    rdchk(16'hFFAB, 8'h3F, "rs_reset");
    rdchk(16'hFFAA, 8'h00, "unmapped");
  endtask

  // refused writes leave everything alone
  task automatic t_protect;
    wr(16'hFFA8, 16'hA5E7, 1'b0);
    rdchk(16'hFFA8, 8'h18, "byte_wr");
    wr(16'hFFA8, 16'h33E7);
    rdchk(16'hFFA8, 8'h18, "bad_pw");
    wr(16'hFFAA, 16'hA540);
    rdchk(16'hFFAB, 8'h3F, "rs_wrong_pw");
    wr(16'hFFAA, 16'h5A40);
    rdchk(16'hFFAB, 8'h7F, "oe_set");
    wr(16'hFFAA, 16'h5A00);
    rdchk(16'hFFAB, 8'h3F, "oe_clr");
    wr(16'hFFA8, 16'h5A33);
    rdchk(16'hFFA9, 8'h00, "cnt_halted");
  endtask

  // a load right after enabling may gain at most one tick; a frozen enable adds none
  task automatic t_count;
    logic [7:0] v;
    wr(16'hFFA8, 16'hA520);
    wr(16'hFFA8, 16'h5A10);
    ce_i = 1'b0;
    repeat (20) @(negedge clk_i);
    ce_i = 1'b1;
    rd(16'hFFA9, v);
    check("cnt_load", {7'h00, v == 8'h10 || v == 8'h11}, 8'h01);
    wr(16'hFFA8, 16'hA500);
    rdchk(16'hFFA9, 8'h00, "cnt_stop");
  endtask

  // six divisor periods give five to seven ticks (up to nine at /2), neighbours fall outside
  task automatic t_cks;
    int divs[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
    logic [7:0] v;
    for (int c = 0; c < 8; c++)
    begin
      wr(16'hFFA8, {13'h14A4, c[2:0]});
      repeat (6 * divs[c]) @(negedge clk_i);
      rd(16'hFFA9, v);
      check("cks_rate", {7'h00, v >= 5 && v <= 7 + 4 / divs[c]}, 8'h01);
      wr(16'hFFA8, 16'hA500);
    end
  endtask

  task automatic t_interval;
    int i;
    wr(16'hFFA8, 16'hA520);
    wr(16'hFFA8, 16'h5AFE);
    for (i = 0; i < 40 && irq_o !== 1'b1; i++) @(negedge clk_i);
    check("irq_rise", {7'h00, irq_o}, 8'h01);
    check("no_chip_rst", {7'h00, chip_o}, 8'h00);
    wr(16'hFFA8, 16'hA520);
    rdchk(16'hFFA8, 8'hB8, "flag_unread");
    wr(16'hFFA8, 16'hA520);
    rdchk(16'hFFA8, 8'h38, "flag_clr");
    check("irq_fall", {7'h00, irq_o}, 8'h00);
    wr(16'hFFA8, 16'hA5A0);
    rdchk(16'hFFA8, 8'h38, "flag_wr1");
    wr(16'hFFA8, 16'hA500);
  endtask

  // overflow in watchdog mode, then clear and pin reset
  task automatic t_watchdog(input logic oe);
    int i;
    int n_int;
    int n_ext;
    n_int = 0;
    n_ext = 0;
    wr(16'hFFAA, {9'h0B4, oe, 6'h00});
    wr(16'hFFA8, 16'hA560);
    wr(16'hFFA8, 16'h5AF0);
    for (i = 0; i < 200 && chip_o !== 1'b1; i++) @(negedge clk_i);
    for (i = 0; i < 100 && chip_o === 1'b1; i++)
    begin
      n_int++;
      n_ext += (pin_n_o === 1'b0);
      @(negedge clk_i);
    end
    check("int_len", n_int[7:0], INT_N[7:0]);
    check("ext_len", n_ext[7:0], oe ? EXT_N[7:0] : 8'h00);
    rdchk(16'hFFAB, {1'b1, oe, 6'h3F}, "ind_set");
    rdchk(16'hFFA8, 8'h18, "cs_after_wd");
    wr(16'hFFAA, 16'hA500);
    rdchk(16'hFFAB, {1'b0, oe, 6'h3F}, "ind_clr");
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    rdchk(16'hFFAB, 8'h3F, "rs_pin_rst");
  endtask

  // standby keeps only the clock select of the control/status register
  task automatic t_standby;
    wr(16'hFFA8, 16'hA527);
    rdchk(16'hFFA8, 8'h3F, "cs_write");
    standby_i = 1'b1;
    @(negedge clk_i);
    standby_i = 1'b0;
    rdchk(16'hFFA8, 8'h1F, "cs_standby");
    rdchk(16'hFFA9, 8'h00, "cnt_standby");
    wr(16'hFFA8, 16'hA500);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    standby_i = 1'b0;
    addr_i = 16'h0000;
    wr_i = 1'b0;
    wr_word_i = 1'b0;
    wdata_i = 16'h0000;
    rd_i = 1'b0;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset_values();
    t_protect();
    t_count();
    t_interval();
    t_watchdog(1'b1);
    t_watchdog(1'b0);
    t_standby();
    t_cks();
    end_of_test();
  end
endmodule
